// file: hw/abei_pkg.sv
// Package for the abnormal-end interrupt block of one tape channel.
// Assumes a 32-bit APB slave and a 20 MHz system clock.
package abei_pkg;
  // Register byte offsets
  localparam logic [7:0] ABEI_CTRL_OFS = 8'h00;
  localparam logic [7:0] ABEI_FUNC_OFS = 8'h04;
  localparam logic [7:0] ABEI_STAT_OFS = 8'h08;
  localparam logic [7:0] ABEI_IRQS_OFS = 8'h0C;
  localparam logic [7:0] ABEI_MASK_OFS = 8'h10;
  // Control fields
  localparam int ABEI_CTRL_EN_BIT = 0;
  localparam int ABEI_CTRL_CONN_BIT = 1;
  localparam logic [1:0] ABEI_CTRL_RST = 2'h0;
  // Function code group and the abnormal-end clear code (octal 0025)
  localparam logic [11:0] ABEI_FUNC_GRP = 12'h0010;
  localparam logic [11:0] ABEI_FUNC_GRP_MASK = 12'h0FF8;
  localparam logic [11:0] ABEI_FUNC_CLR_ABN = 12'h0015;
  // Abnormal condition bit positions
  localparam int ABEI_C_EOT = 0;
  localparam int ABEI_C_FMK = 1;
  localparam int ABEI_C_LDP = 2;
  localparam int ABEI_C_VPE = 3;
  localparam int ABEI_C_LPE = 4;
  localparam int ABEI_C_LOST = 5;
  localparam int ABEI_C_RNR = 6;
  localparam int ABEI_C_SBS = 7;
  localparam int ABEI_NCOND = 8;
  // Sticky event bits
  localparam int ABEI_EV_SET = 0;
  localparam int ABEI_EV_BLK = 1;
  localparam logic [1:0] ABEI_EV_RST = 2'h0;
  localparam int ABEI_NSTAT = 12;
endpackage

// file: hw/abei_top.sv
// Abnormal-end interrupt logic of one tape channel, with APB registers.
// Assumes tape unit and channel pins are asynchronous to CLOCK.
// Operation
// - Set pending on end of record, condition, enable
// - End of tape, file mark during search file mark, load point count
// - Vertical or longitudinal parity error counts while a transfer is active
// - Lost data while a transfer is active counts as abnormal
// - Ready to not ready transition counts
// - Skip-bad-spot parity error counts
// - Pending blocks tape transfers until cleared
// - Any 002X function code clears pending
// - Chained transfers interrupt without waiting
// - Status lines driven only while connected
// - Pending drives interrupt request and indicator
`timescale 1ns/1ps
module abei_top
  import abei_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic END_OF_RECORD,
  input wire logic END_OF_TAPE,
  input wire logic FILE_MARK,
  input wire logic SEARCH_FILE_MARK,
  input wire logic LOAD_POINT,
  input wire logic UNIT_READY,
  input wire logic TRANSFER_ACTIVE,
  input wire logic SKIP_BAD_SPOT,
  input wire logic VERT_PARITY_ERR,
  input wire logic LONG_PARITY_ERR,
  input wire logic LOST_DATA,
  input wire logic CHANNEL_BUSY,
  input wire logic MASTER_CLEAR_PULSE,
  input wire logic [11:0] STATUS_IN,
  input wire logic XFER_REQ,
  output logic XFER_GRANT,
  output logic [11:0] STATUS_OUT,
  output logic STATUS_OE,
  output logic CHANNEL_IRQ,
  output logic IRQ_LAMP,
  output logic IRQ
);
  localparam int NSYNC = 12;
  // Two-stage synchronisers for all tape unit and channel pin inputs; APB and RESET pins are used directly
  logic [NSYNC-1:0] sync1, sync2;
  logic [NSYNC-1:0] pins;
  logic [11:0] st_s1, st_s2;
  assign pins = {XFER_REQ, MASTER_CLEAR_PULSE, CHANNEL_BUSY, LOST_DATA,
                 LONG_PARITY_ERR, VERT_PARITY_ERR, SKIP_BAD_SPOT,
                 TRANSFER_ACTIVE, UNIT_READY, LOAD_POINT,
                 SEARCH_FILE_MARK, FILE_MARK};
  logic eor_s1, eor_s2, eot_s1, eot_s2;
  // Sync flops: first stage read only by the second
  always_ff @(posedge CLOCK) begin
    sync1 <= pins;
    sync2 <= sync1;
    st_s1 <= STATUS_IN;
    st_s2 <= st_s1;
    eor_s1 <= END_OF_RECORD;
    eor_s2 <= eor_s1;
    eot_s1 <= END_OF_TAPE;
    eot_s2 <= eot_s1;
  end
  // Named synchronised signals
  logic fmk, srch, ldp, rdy, act, sbs, vpe, lpe, lost, mc, xreq;
  assign fmk = sync2[0];
  assign srch = sync2[1];
  assign ldp = sync2[2];
  assign rdy = sync2[3];
  assign act = sync2[4];
  assign sbs = sync2[5];
  assign vpe = sync2[6];
  assign lpe = sync2[7];
  assign lost = sync2[8];
  // Channel busy deliberately unused: no wait for not busy in chaining
  assign mc = sync2[10];
  assign xreq = sync2[11];

  // Registered state
  logic rdy_d, eor_d;
  logic [1:0] ctrl;
  logic pending;
  logic [1:0] irqs, mask;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [11:0] status_out;
  logic status_oe, grant;
  logic rnr_latch;
  logic [ABEI_NCOND-1:0] cond;
  logic eor_rise, func_wr, func_clr;
  logic next_rdy_d, next_eor_d, next_pending, next_rnr_latch;
  logic [1:0] next_ctrl, next_irqs, next_mask;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [11:0] next_status_out;
  logic next_status_oe, next_grant;
  logic acc, wr, rd_ok;

  // Condition vector gathered from tape status
  always_comb begin
    cond = '0;
    cond[ABEI_C_EOT] = eot_s2;
    cond[ABEI_C_FMK] = fmk & srch;
    cond[ABEI_C_LDP] = ldp;
    cond[ABEI_C_VPE] = vpe & act & ~sbs;
    cond[ABEI_C_LPE] = lpe & act & ~sbs;
    cond[ABEI_C_LOST] = lost & act;
    cond[ABEI_C_RNR] = rnr_latch;
    cond[ABEI_C_SBS] = (vpe | lpe) & sbs;
  end

  assign acc = PSEL & PENABLE & pready;
  assign wr = acc & PWRITE;
  assign eor_rise = eor_s2 & ~eor_d;
  assign func_wr = wr && (PADDR == ABEI_FUNC_OFS);
  // Any code of the 002X group clears, 0025 among them
  assign func_clr = func_wr &&
    ((PWDATA[11:0] & ABEI_FUNC_GRP_MASK) == ABEI_FUNC_GRP);

  // Next-state logic: pending, latches, registers, bus
  always_comb begin
    next_rdy_d = rdy;
    next_eor_d = eor_s2;
    next_ctrl = ctrl;
    next_mask = mask;
    next_irqs = irqs;
    next_pending = pending;
    next_rnr_latch = rnr_latch;
    // Ready drop caught and held until the record ends
    if (eor_rise) begin
      next_rnr_latch = 1'b0;
    end
    if (rdy_d & ~rdy) begin
      next_rnr_latch = 1'b1;
    end
    // Clearing events first, so a same-cycle set wins
    if (func_clr | mc) begin
      next_pending = 1'b0;
    end
    // Set regardless of channel busy, chained or not
    if (eor_rise && (cond != '0) && ctrl[ABEI_CTRL_EN_BIT]) begin
      next_pending = 1'b1;
    end
    if (wr && PADDR == ABEI_CTRL_OFS) begin
      next_ctrl = PWDATA[1:0];
    end
    if (wr && PADDR == ABEI_MASK_OFS) begin
      next_mask = PWDATA[1:0];
    end
    if (wr && PADDR == ABEI_IRQS_OFS) begin
      next_irqs = irqs & ~PWDATA[1:0];
    end
    // Hardware set wins over write-one-to-clear
    if (next_pending & ~pending) begin
      next_irqs[ABEI_EV_SET] = 1'b1;
    end
    if (xreq & pending) begin
      next_irqs[ABEI_EV_BLK] = 1'b1;
    end
    if (mc) begin
      next_ctrl = ABEI_CTRL_RST;
    end
    next_grant = xreq & ~next_pending;
    next_status_oe = ctrl[ABEI_CTRL_CONN_BIT];
    next_status_out = ctrl[ABEI_CTRL_CONN_BIT] ? st_s2 : 12'h000;
    // APB: no wait state, answer registered in the setup cycle
    next_pready = PSEL & ~PENABLE;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    rd_ok = 1'b1;
    case (PADDR)
      ABEI_CTRL_OFS: next_prdata = {30'h0, ctrl};
      ABEI_FUNC_OFS: next_prdata = 32'h0000_0000;
      ABEI_STAT_OFS: next_prdata = {23'h0, pending, cond};
      ABEI_IRQS_OFS: next_prdata = {30'h0, irqs};
      ABEI_MASK_OFS: next_prdata = {30'h0, mask};
      default: rd_ok = 1'b0;
    endcase
    if (PSEL & ~PENABLE & ~rd_ok) begin
      next_pslverr = 1'b1;
    end
  end

  // State registers
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      rdy_d <= 1'b0;
      eor_d <= 1'b0;
      ctrl <= ABEI_CTRL_RST;
      mask <= ABEI_EV_RST;
      irqs <= ABEI_EV_RST;
      pending <= 1'b0;
      rnr_latch <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      status_out <= 12'h000;
      status_oe <= 1'b0;
      grant <= 1'b0;
    end else begin
      rdy_d <= next_rdy_d;
      eor_d <= next_eor_d;
      ctrl <= next_ctrl;
      mask <= next_mask;
      irqs <= next_irqs;
      pending <= next_pending;
      rnr_latch <= next_rnr_latch;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      status_out <= next_status_out;
      status_oe <= next_status_oe;
      grant <= next_grant;
    end
  end

  // Channel interrupt and indicator flops mirror pending; IRQ takes the masked events
  logic chan_irq, lamp, irq;
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      chan_irq <= 1'b0;
      lamp <= 1'b0;
      irq <= 1'b0;
    end else begin
      chan_irq <= next_pending;
      lamp <= next_pending;
      irq <= |(next_irqs & next_mask);
    end
  end

  assign PRDATA = prdata;
  assign PREADY = pready;
  assign PSLVERR = pslverr;
  assign XFER_GRANT = grant;
  assign STATUS_OUT = status_out;
  assign STATUS_OE = status_oe;
  assign CHANNEL_IRQ = chan_irq;
  assign IRQ_LAMP = lamp;
  assign IRQ = irq;

  // Checks, all on CLOCK; held off while reset is applied
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);
  // Abnormal end event as the rules put it, for the checks below
  logic set_ev;
  assign set_ev = eor_rise && (cond != '0) && ctrl[ABEI_CTRL_EN_BIT];
  // Pending flag: set only by the event, held, then cleared
  pend_set_a: assert property (
    set_ev |=> pending)
    else $error("pending not set");
  pend_only_a: assert property (
    !pending && !set_ev |=> !pending)
    else $error("pending set without event");
  pend_hold_a: assert property (
    pending && !func_clr && !mc |=> pending)
    else $error("pending dropped");
  func_clr_a: assert property (
    func_clr && !set_ev |=> !pending)
    else $error("func clear missed");
  mc_clr_a: assert property (
    mc && !set_ev |=> !pending)
    else $error("master clear missed");
  // A busy channel must not delay the interrupt
  busy_ind_a: assert property (
    set_ev && sync2[9] |=> pending)
    else $error("chained wait");
  // Transfers refused, and the refusal flagged, while pending
  xfer_blk_a: assert property (
    pending |-> !grant)
    else $error("grant while pending");
  blk_flag_a: assert property (
    xreq && pending |=> irqs[ABEI_EV_BLK])
    else $error("refusal not flagged");
  // Request and indicator follow the flag
  irq_follow_a: assert property (
    ##1 chan_irq == pending && lamp == pending)
    else $error("irq mismatch");
  // Status lines gated by the connect bit
  stat_gate_a: assert property (
    !ctrl[ABEI_CTRL_CONN_BIT] |=> !status_oe && status_out == 12'h000)
    else $error("status leak");
  stat_pass_a: assert property (
    ctrl[ABEI_CTRL_CONN_BIT] |=> status_oe && status_out == $past(st_s2))
    else $error("status not passed");
  // Each abnormal condition reaches the vector
  eot_cond_a: assert property (
    eot_s2 |-> cond[ABEI_C_EOT])
    else $error("eot missing");
  fmk_cond_a: assert property (
    fmk && srch |-> cond[ABEI_C_FMK])
    else $error("file mark missing");
  ldp_cond_a: assert property (
    ldp |-> cond[ABEI_C_LDP])
    else $error("load point missing");
  par_cond_a: assert property (
    act && !sbs && vpe |-> cond[ABEI_C_VPE])
    else $error("parity missing");
  lpar_cond_a: assert property (
    act && !sbs && lpe |-> cond[ABEI_C_LPE])
    else $error("long parity missing");
  lost_cond_a: assert property (
    act && lost |-> cond[ABEI_C_LOST])
    else $error("lost data missing");
  rnr_cond_a: assert property (
    $fell(rdy) |=> rnr_latch)
    else $error("ready drop lost");
  sbs_cond_a: assert property (
    sbs && (vpe || lpe) |-> cond[ABEI_C_SBS])
    else $error("skip bad spot missing");
  // Main scenarios
  pend_cov: cover property (eor_rise && cond != '0 && ctrl[0] ##1 pending);
  clr_cov: cover property (pending && func_clr ##1 !pending);
  blk_cov: cover property (pending && xreq);
  apb_cov: cover property (PSEL && PENABLE && pready && !PWRITE);
endmodule

// file: tb/abei_tape_model.sv
// Behavioural tape transport: end of record and the condition lines.
// Assumes the bench picks the conditions and pulses go for one cycle.
`timescale 1ns/1ps
module abei_tape_model (
  input wire logic clk,
  input wire logic [7:0] cond,
  input wire logic go,
  output logic eor,
  output logic eot,
  output logic fmk,
  output logic srch,
  output logic ldp,
  output logic rdy,
  output logic act,
  output logic sbs,
  output logic vpe,
  output logic lpe,
  output logic lost
);
  logic [2:0] cnt = 3'h0; // Cycles of end of record left
  // End of record stands four cycles, long enough for the synchroniser
  always_ff @(posedge clk) begin
    if (go) begin
      cnt <= 3'h4;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end
  end
  assign eor = (cnt != 3'h0);
  // Parity and loss come with a running transfer; skip-bad-spot parity needs none
  assign {sbs, rdy, act, lost, lpe, vpe, ldp, srch, fmk, eot} = {cond[7],
    !cond[6], |cond[5:3], cond[5], cond[4], cond[3] | cond[7], cond[2],
    cond[1], cond[1], cond[0]};
endmodule

// file: tb/abnormal_end_interrupt_tb.sv
// Self-checking bench: APB tasks reach the registers, a model the tape.
// Assumes the design answers each APB access within a few cycles.
`timescale 1ns/1ps
module abnormal_end_interrupt_tb;
  import abei_pkg::*;
  logic CLOCK = 1'b0, RESET = 1'b1, PSEL = 1'b0, PENABLE = 1'b0;
  logic PWRITE = 1'b0, CHANNEL_BUSY = 1'b0, MASTER_CLEAR_PULSE = 1'b0;
  logic XFER_REQ = 1'b1, go = 1'b0;
  logic [7:0] PADDR = 8'h00, cond = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [11:0] STATUS_IN = 12'h000;
  logic [31:0] PRDATA;
  logic [11:0] STATUS_OUT;
  logic PREADY, PSLVERR, XFER_GRANT, STATUS_OE, CHANNEL_IRQ, IRQ_LAMP, IRQ;
  wire logic END_OF_RECORD, END_OF_TAPE, FILE_MARK, SEARCH_FILE_MARK;
  wire logic LOAD_POINT, UNIT_READY, TRANSFER_ACTIVE, SKIP_BAD_SPOT;
  wire logic VERT_PARITY_ERR, LONG_PARITY_ERR, LOST_DATA;
  int n_errors = 0, checks_done = 0, cyc = 0;
  abei_top uut (.*);
  abei_tape_model tape (.clk(CLOCK), .cond(cond), .go(go),
    .eor(END_OF_RECORD), .eot(END_OF_TAPE), .fmk(FILE_MARK),
    .srch(SEARCH_FILE_MARK), .ldp(LOAD_POINT), .rdy(UNIT_READY),
    .act(TRANSFER_ACTIVE), .sbs(SKIP_BAD_SPOT), .vpe(VERT_PARITY_ERR),
    .lpe(LONG_PARITY_ERR), .lost(LOST_DATA));
  // Free-running 20 MHz clock
  always #25 CLOCK = ~CLOCK;
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Watchdog: whole run needs well under 3000 cycles
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer: setup, then access until PREADY is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    // Read at the edge, values are those the slave showed up to it
    do begin
      @(posedge CLOCK);
    end while (PREADY !== 1'b1);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLOCK); // Idle cycle keeps drivers single per step
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, x);
  endtask
  // Enough for two synchroniser flops and one register stage
  task automatic settle;
    repeat (4) @(posedge CLOCK);
  endtask
  // End of record from the tape, then look at the interrupt outputs
  task automatic eor_check(input logic exp);
    go <= 1'b1;
    @(posedge CLOCK);
    go <= 1'b0;
    repeat (8) @(posedge CLOCK);
    chk(CHANNEL_IRQ, exp);
    chk(IRQ_LAMP, exp);
  endtask
  initial begin
    logic [31:0] r;
    logic [31:0] xs;
    logic e;
    repeat (16) @(posedge CLOCK);
    RESET <= 1'b0;
    repeat (3) @(posedge CLOCK);
    // All registers read zero after reset
    for (int a = 0; a < 5; a++) rd(8'(a * 4), 32'h0000_0000);
    apb(1'b0, 8'h14, 32'h0000_0000, r, e);
    chk(e, 1'b1); // Unmapped address refused
    chk(XFER_GRANT, 1'b1);
    wr(ABEI_MASK_OFS, 32'h0000_0001);
    wr(ABEI_CTRL_OFS, 32'h0000_0001);
    // Each condition alone, busy channel on odd runs, each clear code
    for (int i = 0; i < 8; i++) begin
      cond <= 8'h01 << i;
      CHANNEL_BUSY <= i[0];
      // Ready drop latch is used up by the end of record itself
      xs = (i == 6) ? 32'h0000_0100 :
        (32'h0000_0100 | (32'h0000_0001 << i));
      settle();
      eor_check(1'b1);
      rd(ABEI_STAT_OFS, xs);
      cond <= 8'h00;
      settle();
      chk(CHANNEL_IRQ, 1'b1);
      chk(XFER_GRANT, 1'b0);
      rd(ABEI_IRQS_OFS, 32'h0000_0003);
      chk(IRQ, 1'b1);
      // A code outside the clearing group leaves the flag alone
      wr(ABEI_FUNC_OFS, {20'h0_0000, ABEI_FUNC_GRP + 12'h008});
      chk(CHANNEL_IRQ, 1'b1);
      wr(ABEI_FUNC_OFS, {20'h0_0000, ABEI_FUNC_GRP + 12'(i)});
      settle();
      chk(CHANNEL_IRQ, 1'b0);
      chk(XFER_GRANT, 1'b1);
      wr(ABEI_IRQS_OFS, 32'h0000_0001);
      settle();
      chk(IRQ, 1'b0); // Refusal bit stays but is masked
      wr(ABEI_MASK_OFS, 32'h0000_0003);
      chk(IRQ, 1'b1); // Refusal event once unmasked
      wr(ABEI_MASK_OFS, 32'h0000_0001);
      rd(ABEI_IRQS_OFS, 32'h0000_0002);
      wr(ABEI_IRQS_OFS, 32'h0000_0002);
    end
    // Enable off, then no condition: no interrupt either way
    cond <= 8'h01;
    CHANNEL_BUSY <= 1'b0;
    wr(ABEI_CTRL_OFS, 32'h0000_0000);
    eor_check(1'b0);
    cond <= 8'h00;
    wr(ABEI_CTRL_OFS, 32'h0000_0003);
    settle();
    eor_check(1'b0);
    // Master clear ends a pending interrupt and the control bits
    cond <= 8'h04;
    settle();
    eor_check(1'b1);
    MASTER_CLEAR_PULSE <= 1'b1;
    settle();
    MASTER_CLEAR_PULSE <= 1'b0;
    settle();
    chk(CHANNEL_IRQ, 1'b0);
    chk(XFER_GRANT, 1'b1);
    rd(ABEI_CTRL_OFS, 32'h0000_0000);
    // Status lines only while connected
    STATUS_IN <= 12'hA5C;
    settle();
    chk(STATUS_OUT, 12'h000);
    chk(STATUS_OE, 1'b0);
    wr(ABEI_CTRL_OFS, 32'h0000_0002);
    settle();
    chk(STATUS_OUT, 12'hA5C);
    chk(STATUS_OE, 1'b1);
    // Grant follows the request once it is withdrawn
    XFER_REQ <= 1'b0;
    settle();
    chk(XFER_GRANT, 1'b0);
    report_and_stop();
  end
endmodule
